// ===== clk_mode_pkg.sv
// Package: register map, field layout, reset values, timing constants and modes
//
// What this block does
// - Select field codes 0..6 pick fast clock divided by 1..64; code 7 picks sub clock.
// - Low source bit routes slow RC (0) or crystal (1) to the sub clock.
// - Fast idle enable keeps fast oscillator running during stop when 1.
// - Slow idle enable keeps sub oscillator running during stop when 1.
// - Both idle enables 0 enters sleep; slow RC runs only with watchdog enabled.
// - Fast idle 0, slow idle 1 enters sub-only idle; fast clock off.
// - Both idle enables 1 enters idle with both clocks running for peripherals.
// - Fast idle 1, slow idle 0 enters fast-only idle; sub clock off.
// - In slow mode fast oscillator follows its own enable bit.
// - Setting fast enable in slow mode clears fast stable flag, then sets it once stable.
// - Setting crystal enable clears crystal stable flag, then sets it once stable.
// - Quick start bit picks short (1) or long (0) crystal settling time.
// - Quick start bit writes are ignored while crystal is system clock source.
// - Clock change completes within four old periods plus source sync delay, but stalls if the old clock stops (fast to sub with fast enable 0).
// - Unimplemented register bits read zero and ignore writes.
// - Wake into fast mode holds CPU until fast stable flag is 1.
package clk_mode_pkg;

    // ---------------------------------------------------------------
    // Register offsets and fields
    // ---------------------------------------------------------------
    localparam logic [1:0] ADDR_SYS_CLK  = 2'h0;
    localparam logic [1:0] ADDR_FAST_RC  = 2'h1;
    localparam logic [1:0] ADDR_CRYSTAL  = 2'h2;

    localparam int SEL_LSB       = 5;
    localparam int SEL_MSB       = 7;
    localparam int LOW_SRC_BIT   = 2;
    localparam int FAST_IDLE_BIT = 1;
    localparam int SLOW_IDLE_BIT = 0;
    localparam int FLAG_BIT      = 1;
    localparam int ENABLE_BIT    = 0;
    localparam int QUICK_BIT     = 2;

    localparam logic [2:0] SEL_SUB     = 3'h7;
    localparam logic [2:0] SEL_RESET   = 3'h0;
    localparam logic       FAST_EN_RST = 1'b1;

    // ---------------------------------------------------------------
    // Timing at 100 MHz
    // ---------------------------------------------------------------
    localparam int CLK_MHZ          = 100;
    localparam int FAST_SETTLE_US   = 16;
    localparam int XTAL_QUICK_US    = 1000;
    localparam int XTAL_SLOW_US     = 2000;
    localparam int FAST_SETTLE_CYC  = FAST_SETTLE_US * CLK_MHZ;
    localparam int XTAL_QUICK_CYC   = XTAL_QUICK_US * CLK_MHZ;
    localparam int XTAL_SLOW_CYC    = XTAL_SLOW_US * CLK_MHZ;
    localparam int SWITCH_PERIODS   = 4;
    localparam logic [11:0] FAST_PERIOD = 12'h019;
    localparam logic [11:0] SUB_PERIOD  = 12'hBEC;
    localparam int CNT_W            = 24;

    typedef enum logic [2:0] {
        MODE_RUN, MODE_SLEEP, MODE_IDLE_SUB, MODE_IDLE_BOTH, MODE_IDLE_FAST
    } power_mode_type;

endpackage

// ===== osc_settle.sv
// Oscillator model: enable, settle counter and stable flag
`timescale 1ns/1ps
module osc_settle (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              run,
    input  wire logic [23:0]       settle_cyc,
    output logic                   stable
);
    logic [23:0] count_ff;

    // Flag clears while off or freshly enabled, sets after settle count
    always_ff @(posedge mclk) begin
        if (!rst_n || !run) begin
            count_ff <= 24'h00_0000;
            stable   <= 1'b0;
        end else if (count_ff >= settle_cyc) begin
            stable <= 1'b1;
        end else begin
            count_ff <= count_ff + 24'h00_0001;
        end
    end
endmodule

// ===== clk_tick.sv
// Enable-pulse divider producing one tick every period cycles
`timescale 1ns/1ps
module clk_tick (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic [11:0] period,
    output logic             tick
);
    logic [11:0] cnt_ff;

    // Count down and emit a one-cycle tick on wrap
    always_ff @(posedge mclk) begin
        if (!rst_n || !run) begin
            cnt_ff <= 12'h000;
            tick   <= 1'b0;
        end else if (cnt_ff == 12'h000) begin
            cnt_ff <= period - 12'h001;
            tick   <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff - 12'h001;
            tick   <= 1'b0;
        end
    end
endmodule

// ===== clk_mode_ctrl.sv
// System clock and power-mode controller top level
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module clk_mode_ctrl #(
    parameter int FAST_SETTLE = clk_mode_pkg::FAST_SETTLE_CYC,
    parameter int XTAL_QUICK  = clk_mode_pkg::XTAL_QUICK_CYC,
    parameter int XTAL_SLOW   = clk_mode_pkg::XTAL_SLOW_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic [7:0]      rdata,
    input  wire logic       stop_req,
    input  wire logic       wake_req,
    input  wire logic       watchdog_enable,
    output logic            cpu_run,
    output logic            sys_tick,
    output logic            fast_periph_on,
    output logic            sub_periph_on,
    output logic            slow_rc_on,
    output logic            fast_osc_run,
    output logic            crystal_run,
    output logic            on_sub_clock,
    output logic            switch_busy
);
    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [2:0] sys_clk_select_ff;
    logic       low_clk_source_select_ff;
    logic       fast_osc_idle_enable_ff;
    logic       slow_osc_idle_enable_ff;
    logic       fast_osc_enable_ff;
    logic       crystal_enable_ff;
    logic       crystal_quick_start_ff;
    logic       wd_s1_ff;
    logic       wd_s2_ff;
    clk_mode_pkg::power_mode_type mode_ff;
    logic       waking_ff;
    logic [2:0] active_sel_ff;
    logic       active_low_src_ff;
    logic [3:0] switch_cnt_ff;
    logic [7:0] nxt_rdata;

    logic       fast_osc_stable_flag;
    logic       crystal_stable_flag;
    logic       fast_tick;
    logic       sub_tick;
    logic       xtal_is_sys;
    logic [11:0] fast_div;
    logic [23:0] xtal_settle;
    logic       fast_needed;
    logic       sub_needed;

    // Crystal counts as system source when selected for sub and sub chosen
    assign xtal_is_sys = (sys_clk_select_ff == clk_mode_pkg::SEL_SUB)
                         && low_clk_source_select_ff;

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    // System clock control register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sys_clk_select_ff        <= clk_mode_pkg::SEL_RESET;
            low_clk_source_select_ff <= 1'b0;
            fast_osc_idle_enable_ff  <= 1'b0;
            slow_osc_idle_enable_ff  <= 1'b0;
        end else if (wr_en && addr == clk_mode_pkg::ADDR_SYS_CLK) begin
            sys_clk_select_ff <= wdata[clk_mode_pkg::SEL_MSB:clk_mode_pkg::SEL_LSB];
            low_clk_source_select_ff <= wdata[clk_mode_pkg::LOW_SRC_BIT];
            fast_osc_idle_enable_ff  <= wdata[clk_mode_pkg::FAST_IDLE_BIT];
            slow_osc_idle_enable_ff  <= wdata[clk_mode_pkg::SLOW_IDLE_BIT];
        end
    end

    // Fast RC control register; flag bit is read only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fast_osc_enable_ff <= clk_mode_pkg::FAST_EN_RST;
        end else if (wr_en && addr == clk_mode_pkg::ADDR_FAST_RC) begin
            fast_osc_enable_ff <= wdata[clk_mode_pkg::ENABLE_BIT];
        end
    end

    // Crystal control register; quick start frozen while crystal drives system
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            crystal_enable_ff      <= 1'b0;
            crystal_quick_start_ff <= 1'b0;
        end else if (wr_en && addr == clk_mode_pkg::ADDR_CRYSTAL) begin
            crystal_enable_ff <= wdata[clk_mode_pkg::ENABLE_BIT];
            if (!xtal_is_sys) begin
                crystal_quick_start_ff <= wdata[clk_mode_pkg::QUICK_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    // Unused bits read zero; unmapped address reads zero
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (addr)
            clk_mode_pkg::ADDR_SYS_CLK: begin
                nxt_rdata[clk_mode_pkg::SEL_MSB:clk_mode_pkg::SEL_LSB] = sys_clk_select_ff;
                nxt_rdata[clk_mode_pkg::LOW_SRC_BIT]   = low_clk_source_select_ff;
                nxt_rdata[clk_mode_pkg::FAST_IDLE_BIT] = fast_osc_idle_enable_ff;
                nxt_rdata[clk_mode_pkg::SLOW_IDLE_BIT] = slow_osc_idle_enable_ff;
            end
            clk_mode_pkg::ADDR_FAST_RC: begin
                nxt_rdata[clk_mode_pkg::FLAG_BIT]   = fast_osc_stable_flag;
                nxt_rdata[clk_mode_pkg::ENABLE_BIT] = fast_osc_enable_ff;
            end
            clk_mode_pkg::ADDR_CRYSTAL: begin
                nxt_rdata[clk_mode_pkg::QUICK_BIT]  = crystal_quick_start_ff;
                nxt_rdata[clk_mode_pkg::FLAG_BIT]   = crystal_stable_flag;
                nxt_rdata[clk_mode_pkg::ENABLE_BIT] = crystal_enable_ff;
            end
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Read data valid the cycle after the strobe only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            rdata <= nxt_rdata;
        end else begin
            rdata <= 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // Watchdog enable synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wd_s1_ff <= 1'b0;
            wd_s2_ff <= 1'b0;
        end else begin
            wd_s1_ff <= watchdog_enable;
            wd_s2_ff <= wd_s1_ff;
        end
    end

    // ---------------------------------------------------------------
    // Power mode machine
    // ---------------------------------------------------------------
    // Stop picks mode from idle enables; wake returns to run
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode_ff   <= clk_mode_pkg::MODE_RUN;
            waking_ff <= 1'b1;
        end else begin
            unique case (mode_ff)
                clk_mode_pkg::MODE_RUN: begin
                    if (stop_req) begin
                        unique case ({fast_osc_idle_enable_ff, slow_osc_idle_enable_ff})
                            2'b00: mode_ff <= clk_mode_pkg::MODE_SLEEP;
                            2'b01: mode_ff <= clk_mode_pkg::MODE_IDLE_SUB;
                            2'b11: mode_ff <= clk_mode_pkg::MODE_IDLE_BOTH;
                            2'b10: mode_ff <= clk_mode_pkg::MODE_IDLE_FAST;
                        endcase
                    end
                    if (waking_ff && (active_sel_ff == clk_mode_pkg::SEL_SUB
                                      || fast_osc_stable_flag)) begin
                        waking_ff <= 1'b0;
                    end
                end
                default: begin
                    if (wake_req) begin
                        mode_ff   <= clk_mode_pkg::MODE_RUN;
                        waking_ff <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Oscillator demand per mode
    always_comb begin
        unique case (mode_ff)
            clk_mode_pkg::MODE_RUN: begin
                fast_needed = fast_osc_enable_ff
                              || sys_clk_select_ff != clk_mode_pkg::SEL_SUB;
                sub_needed  = 1'b1;
            end
            clk_mode_pkg::MODE_SLEEP: begin
                fast_needed = 1'b0;
                sub_needed  = 1'b0;
            end
            clk_mode_pkg::MODE_IDLE_SUB: begin
                fast_needed = 1'b0;
                sub_needed  = 1'b1;
            end
            clk_mode_pkg::MODE_IDLE_BOTH: begin
                fast_needed = 1'b1;
                sub_needed  = 1'b1;
            end
            default: begin
                fast_needed = 1'b1;
                sub_needed  = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Oscillators
    // ---------------------------------------------------------------
    assign xtal_settle = crystal_quick_start_ff ? 24'(XTAL_QUICK) : 24'(XTAL_SLOW);

    osc_settle u_fast_osc (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .run        (fast_needed),
        .settle_cyc (24'(FAST_SETTLE)),
        .stable     (fast_osc_stable_flag)
    );

    osc_settle u_crystal (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .run        (crystal_enable_ff),
        .settle_cyc (xtal_settle),
        .stable     (crystal_stable_flag)
    );

    // ---------------------------------------------------------------
    // Clock switching: hold old source until switch count expires
    // ---------------------------------------------------------------
    // Counts four old periods, then adopts new select on a tick boundary
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            active_sel_ff     <= clk_mode_pkg::SEL_RESET;
            active_low_src_ff <= 1'b0;
            switch_cnt_ff     <= 4'h0;
        end else if (active_sel_ff != sys_clk_select_ff
                     || active_low_src_ff != low_clk_source_select_ff) begin
            if (switch_cnt_ff == 4'(clk_mode_pkg::SWITCH_PERIODS)) begin
                if (sys_clk_select_ff == clk_mode_pkg::SEL_SUB ? sub_tick : fast_tick) begin
                    active_sel_ff     <= sys_clk_select_ff;
                    active_low_src_ff <= low_clk_source_select_ff;
                    switch_cnt_ff     <= 4'h0;
                end
            end else if (sys_tick) begin
                switch_cnt_ff <= switch_cnt_ff + 4'h1;
            end
        end else begin
            switch_cnt_ff <= 4'h0;
        end
    end

    // Fast clock divided per select code; while on sub, per the target code
    assign fast_div = clk_mode_pkg::FAST_PERIOD << ((active_sel_ff != clk_mode_pkg::SEL_SUB)
                      ? active_sel_ff
                      : (sys_clk_select_ff == clk_mode_pkg::SEL_SUB ? 3'h0 : sys_clk_select_ff));

    clk_tick u_fast_tick (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .run    (fast_osc_stable_flag),
        .period (fast_div),
        .tick   (fast_tick)
    );

    // Sub clock ~32 kHz: 3052 cycles per period either source
    clk_tick u_sub_tick (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .run    (sub_needed && (!active_low_src_ff || crystal_stable_flag)),
        .period (clk_mode_pkg::SUB_PERIOD),
        .tick   (sub_tick)
    );

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cpu_run        <= 1'b0;
            sys_tick       <= 1'b0;
            fast_periph_on <= 1'b0;
            sub_periph_on  <= 1'b0;
            slow_rc_on     <= 1'b0;
            fast_osc_run   <= 1'b0;
            crystal_run    <= 1'b0;
            on_sub_clock   <= 1'b0;
            switch_busy    <= 1'b0;
        end else begin
            cpu_run        <= mode_ff == clk_mode_pkg::MODE_RUN && !waking_ff;
            sys_tick       <= mode_ff == clk_mode_pkg::MODE_RUN && !waking_ff &&
                              (active_sel_ff == clk_mode_pkg::SEL_SUB ? sub_tick
                                                                      : fast_tick);
            fast_periph_on <= fast_needed && fast_osc_stable_flag;
            sub_periph_on  <= sub_needed;
            slow_rc_on     <= (mode_ff == clk_mode_pkg::MODE_SLEEP) ? wd_s2_ff
                              : !active_low_src_ff || sub_needed;
            fast_osc_run   <= fast_needed;
            crystal_run    <= crystal_enable_ff && (sub_needed || !active_low_src_ff);
            on_sub_clock   <= active_sel_ff == clk_mode_pkg::SEL_SUB;
            switch_busy    <= active_sel_ff != sys_clk_select_ff;
        end
    end

endmodule

// ===== clk_mode_monitor.sv
// Checker for the clock mode controller ports
`timescale 1ns/1ps
module clk_mode_monitor (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    input wire logic       stop_req,
    input wire logic       cpu_run,
    input wire logic       sys_tick,
    input wire logic       fast_periph_on,
    input wire logic       sub_periph_on,
    input wire logic       fast_osc_run,
    input wire logic       on_sub_clock,
    input wire logic       switch_busy
);
    logic [2:0]  sel_ff;
    logic        fi_ff, si_ff, en_ff, seen_ff;
    logic [15:0] gap_ff;
    logic [2:0]  tk_ff;

    // ---------------------------------------------
    // Shadow copies of the written control bits
    // ---------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sel_ff <= 3'h0;
            fi_ff <= 1'b0;
            si_ff <= 1'b0;
            en_ff <= 1'b1;
        end else if (wr_en && addr == clk_mode_pkg::ADDR_SYS_CLK) begin
            sel_ff <= wdata[7:5];
            fi_ff <= wdata[1];
            si_ff <= wdata[0];
        end else if (wr_en && addr == clk_mode_pkg::ADDR_FAST_RC) begin
            en_ff <= wdata[0];
        end
    end

    // Cycles since the last tick, saturating
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gap_ff <= 16'h0000;
            seen_ff <= 1'b0;
        end else if (sys_tick) begin
            gap_ff <= 16'h0001;
            seen_ff <= 1'b1;
        end else if (gap_ff != 16'hFFFF) begin
            gap_ff <= gap_ff + 16'h0001;
        end
    end

    // Ticks counted inside one switch
    always_ff @(posedge mclk) begin
        if (!rst_n || !switch_busy) tk_ff <= 3'h0;
        else if (sys_tick && tk_ff != 3'h7) tk_ff <= tk_ff + 3'h1;
    end

    function automatic logic [7:0] unused_mask(input logic [1:0] a);
        case (a)
            2'h0: return 8'h18;
            2'h1: return 8'hFC;
            2'h2: return 8'hF8;
            default: return 8'hFF;
        endcase
    endfunction

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence stop_taken;
        stop_req && cpu_run;
    endsequence
    sequence parked;
        !cpu_run && fast_periph_on == fi_ff && sub_periph_on == si_ff;
    endsequence

    unused_zero_a: assert property ($past(rd_en) |-> (rdata & unused_mask($past(addr))) == 8'h00)
        else $error("unused read bits not zero");
    stop_entry_a: assert property (stop_taken |-> ##[1:2] !cpu_run)
        else $error("cpu kept running after stop");
    mode_clocks_a: assert property (stop_taken |-> ##2 parked)
        else $error("peripheral clocks wrong in stop");
    tick_gap_a: assert property (sys_tick && seen_ff |-> gap_ff >= 16'h0019)
        else $error("system tick too close");
    switch_ticks_a: assert property (switch_busy |-> tk_ff <= 3'h6)
        else $error("clock switch too long");
    switch_result_a: assert property ($fell(switch_busy) |-> ##[0:1] on_sub_clock == (sel_ff == 3'h7))
        else $error("wrong clock after switch");
    wake_fast_a: assert property ($rose(cpu_run) |-> fast_periph_on || on_sub_clock)
        else $error("cpu started without fast oscillator");
    slow_fast_a: assert property (on_sub_clock && $past(on_sub_clock) && !switch_busy
        && cpu_run && $past(cpu_run) && en_ff == $past(en_ff) |-> fast_osc_run == en_ff)
        else $error("fast oscillator ignores enable in slow mode");
endmodule

bind clk_mode_ctrl clk_mode_monitor mon (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .stop_req(stop_req),
    .cpu_run(cpu_run), .sys_tick(sys_tick), .fast_periph_on(fast_periph_on),
    .sub_periph_on(sub_periph_on), .fast_osc_run(fast_osc_run),
    .on_sub_clock(on_sub_clock), .switch_busy(switch_busy));

// ===== cpu_model.sv
// CPU side model: register bus cycles, stop and wake requests
`timescale 1ns/1ps
module cpu_model (
    input  wire logic       mclk,
    input  wire logic [7:0] rdata,
    output logic [1:0]      addr,
    output logic [7:0]      wdata,
    output logic            wr_en,
    output logic            rd_en,
    output logic            stop_req,
    output logic            wake_req
);
    // Idle bus at time zero
    initial begin
        addr = 2'h0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        stop_req = 1'b0;
        wake_req = 1'b0;
    end

    // Released address and data show the inverse of the last value
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        addr <= ~a;
        @(posedge mclk);
        d = rdata;
    endtask

    // One-cycle requests
    task automatic stop();
        @(posedge mclk);
        stop_req <= 1'b1;
        @(posedge mclk);
        stop_req <= 1'b0;
    endtask

    task automatic wake();
        @(posedge mclk);
        wake_req <= 1'b1;
        @(posedge mclk);
        wake_req <= 1'b0;
    endtask
endmodule

// ===== system_clock_mode_control_tb_top.sv
// Testbench for the clock mode controller
`timescale 1ns/1ps
module system_clock_mode_control_tb_top;
    typedef struct {logic [2:0] sel; logic [15:0] per; logic sub;} sel_row_type;
    typedef struct {logic fi; logic si; logic wd;} mode_row_type;
    logic        mclk, rst_n, wdog, wr_en, rd_en, stop_req, wake_req;
    logic [1:0]  addr;
    logic [7:0]  wdata, rdata;
    logic [15:0] rv;
    logic        cpu_run, sys_tick, fast_periph_on, sub_periph_on, slow_rc_on;
    logic        fast_osc_run, crystal_run, on_sub_clock, switch_busy;
    int          errors, cmp_count, n;
    sel_row_type  sel_rows [8];
    mode_row_type mode_rows [5];

    clk_mode_ctrl #(.FAST_SETTLE(20), .XTAL_QUICK(50), .XTAL_SLOW(100)) dut (
        .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .stop_req(stop_req), .wake_req(wake_req),
        .watchdog_enable(wdog), .cpu_run(cpu_run), .sys_tick(sys_tick),
        .fast_periph_on(fast_periph_on), .sub_periph_on(sub_periph_on),
        .slow_rc_on(slow_rc_on), .fast_osc_run(fast_osc_run), .crystal_run(crystal_run),
        .on_sub_clock(on_sub_clock), .switch_busy(switch_busy));

    cpu_model cpu (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .stop_req(stop_req), .wake_req(wake_req));

    // ---------------------------------------------
    // Compare, wait and closing tasks
    // ---------------------------------------------
    task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Kind 0 switch idle, 1 cpu running, 2 tick seen; n holds cycles taken
    task automatic wait_on(input int w, input int lim);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while ((w == 0 ? !switch_busy : (w == 1 ? cpu_run : sys_tick)) !== 1'b1 && n < lim);
        if (n >= lim) begin
            errors++;
            $display("wrong value wait kind %0d expected 1 seen 0", w);
            finish_test();
        end
    endtask

    task automatic reg_is(input logic [1:0] a, input logic [15:0] e);
        cpu.rd(a, rv[7:0]);
        chk_val("register", e, rv);
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        for (int i = 0; i < 7; i++) sel_rows[i] = '{i[2:0], 16'h0019 << i, 1'b0};
        sel_rows[7] = '{3'h7, 16'h0BEC, 1'b1};
        mode_rows = '{'{1'b0, 1'b0, 1'b1}, '{1'b0, 1'b1, 1'b1}, '{1'b1, 1'b1, 1'b1},
                      '{1'b1, 1'b0, 1'b1}, '{1'b0, 1'b0, 1'b0}};
        errors = 0;
        cmp_count = 0;
        rv = 16'h0000;
        rst_n = 1'b0;
        wdog = 1'b1;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        wait_on(1, 300);
        reg_is(2'h0, 16'h0000);
        reg_is(2'h1, 16'h0003);
        reg_is(2'h2, 16'h0000);
        cpu.wr(2'h3, 8'hFF);
        cpu.wr(2'h0, 8'h1F);
        reg_is(2'h0, 16'h0007);
        reg_is(2'h3, 16'h0000);
        $display("test reset and map done");
        // Every select code: switch, then measure the tick period
        for (int i = 0; i < 8; i++) begin
            cpu.wr(2'h0, {sel_rows[i].sel, 5'h00});
            repeat (2) @(posedge mclk);
            wait_on(0, 20000);
            chk_bit("on sub clock", sel_rows[i].sub, on_sub_clock);
            wait_on(2, 4000);
            wait_on(2, 4000);
            chk_val("tick period", sel_rows[i].per, n[15:0]);
        end
        $display("test select table done");
        cpu.wr(2'h1, 8'h00);
        repeat (3) @(posedge mclk);
        chk_bit("fast osc off", 1'b0, fast_osc_run);
        cpu.wr(2'h1, 8'h01);
        repeat (3) @(posedge mclk);
        chk_bit("fast osc on", 1'b1, fast_osc_run);
        cpu.wr(2'h2, 8'h05);
        reg_is(2'h2, 16'h0005);
        repeat (70) @(posedge mclk);
        reg_is(2'h2, 16'h0007);
        cpu.wr(2'h0, 8'hE4);
        repeat (2) @(posedge mclk);
        wait_on(0, 20000);
        chk_bit("crystal run", 1'b1, crystal_run);
        cpu.wr(2'h2, 8'h01);
        reg_is(2'h2, 16'h0007);
        cpu.wr(2'h0, 8'h00);
        repeat (2) @(posedge mclk);
        wait_on(0, 20000);
        cpu.wr(2'h2, 8'h00);
        cpu.wr(2'h2, 8'h01);
        repeat (70) @(posedge mclk);
        reg_is(2'h2, 16'h0001);
        repeat (40) @(posedge mclk);
        reg_is(2'h2, 16'h0003);
        $display("test oscillators done");
        // Each low-power mode, then wake back into fast mode
        foreach (mode_rows[i]) begin
            wdog <= mode_rows[i].wd;
            cpu.wr(2'h0, {6'h00, mode_rows[i].fi, mode_rows[i].si});
            cpu.stop();
            repeat (4) @(posedge mclk);
            chk_bit("cpu run", 1'b0, cpu_run);
            chk_bit("fast periph", mode_rows[i].fi, fast_periph_on);
            chk_bit("sub periph", mode_rows[i].si, sub_periph_on);
            if (!mode_rows[i].fi && !mode_rows[i].si) begin
                chk_bit("slow rc", mode_rows[i].wd, slow_rc_on);
            end
            cpu.wake();
            if (!mode_rows[i].fi) begin
                repeat (2) @(posedge mclk);
                chk_bit("cpu held", 1'b0, cpu_run);
            end
            wait_on(1, 500);
        end
        $display("test power modes done");
        finish_test();
    end
endmodule
